// ==== bench/core_checker_asserts.sv ====
module core_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [10:0] prog_addr,
	input wire logic wdt_clear,
	input wire logic prescaler_clear,
	input wire logic standby
);
	// ==========
	// Bus and core checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	aw_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write not answered");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("write response dropped");
	ar_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
		&& !s_axi_arready) else $error("read not answered");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata)) else $error("read data dropped");
	r_decerr_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'hC
		|=> s_axi_rresp == core_pkg::RESP_DECERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	fetch_span_a: assert property ($changed(prog_addr) |=> $stable(prog_addr) [*3])
		else $error("fetch address held under four clocks");
	wdt_pulse_a: assert property (wdt_clear |=> !wdt_clear)
		else $error("watchdog clear not a pulse");
	psc_pulse_a: assert property (prescaler_clear |=> !prescaler_clear)
		else $error("prescaler clear not a pulse");
	sleep_kick_a: assert property ($rose(standby) |-> ($past(wdt_clear) || wdt_clear)
		or (##1 wdt_clear)) else $error("standby without watchdog clear");
endmodule // core_checker
bind mcu_instruction_decoder core_checker chk_u (.*);

// ==== bench/mcu_instruction_decoder_tb_top.sv ====
module mcu_instruction_decoder_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [10:0] prog_addr;
	logic [13:0] prog_data;
	logic [7:0] port_pins, port_latch;
	logic wdt_clear, prescaler_clear, standby;
	int fails = 0, n_tests = 0, n_wdt = 0, n_psc = 0;
	mcu_instruction_decoder dut_u (.*);
	prog_mem mem_u (.*);
	initial begin
		forever #4 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		n_wdt += int'(wdt_clear === 1'b1);
		n_psc += int'(prescaler_clear === 1'b1);
	end
	// ==========
	// Bus and compare tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// ==========
	// Scenarios
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0] r;
		rd(core_pkg::REG_STATE, d, r);
		chk(d, 32'h0000_1800);
		rd(4'hC, d, r);
		chk({30'h0, r}, {30'h0, core_pkg::RESP_DECERR});
		wr(core_pkg::REG_STATE, 32'h1, r);
		chk({30'h0, r}, {30'h0, core_pkg::RESP_DECERR});
		rd(core_pkg::REG_STATE, d, r);
		chk(d, 32'h0000_1800);
	endtask
	task automatic t_run;
		logic [31:0] d;
		logic [1:0] r;
		int n;
		wr(core_pkg::REG_CTRL, 32'h3, r);
		rd(core_pkg::REG_CTRL, d, r);
		chk(d, 32'h3);
		n = 0;
		while (standby !== 1'b1 && n < 500) begin
			@(posedge aclk);
			n++;
		end
		chk({31'h0, standby}, 32'h1);
		rd(core_pkg::REG_STATE, d, r);
		chk(d[7:0], 32'h0F);
		chk({d[31], d[15:8]}, 32'h112);
		chk(32'(port_latch), 32'hA5);
		chk(n_wdt, 32'h2);
		chk(n_psc, 32'h1);
	endtask
	task automatic t_wake;
		logic [31:0] d;
		logic [1:0] r;
		wr(core_pkg::REG_WAKE, 32'h1, r);
		repeat (40) @(posedge aclk);
		chk({31'h0, standby}, 32'h0);
		chk(32'(prog_addr), 32'h00D);
		rd(core_pkg::REG_STATE, d, r);
		chk(d, 32'h000D_125A);
	endtask
	// ==========
	// Sequence and verdict
	task automatic results;
		if (fails == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_run();
		t_wake();
		results();
	end
	initial begin
		repeat (5000) @(posedge aclk);
		fails++;
		results();
	end
endmodule // mcu_instruction_decoder_tb_top

// ==== bench/prog_mem.sv ====
module prog_mem (
	input wire logic [10:0] prog_addr,
	output logic [13:0] prog_data,
	output logic [7:0] port_pins
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========
	// Program image, some don't-care bits set
	localparam logic [7:0] PIN_LEVEL = 8'hA5;
	localparam logic [13:0] PROG [0:15] = '{14'h330F, 14'h3F01, 14'h0090, 14'h1E10,
		14'h3000, 14'h0B90, 14'h0810, 14'h0085, 14'h0885, 14'h0081, 14'h0064,
		14'h0063, 14'h200E, 14'h280D, 14'h3A3C, 14'h345A};
	assign prog_data = (prog_addr < 11'h010) ? PROG[prog_addr[3:0]] : core_pkg::W_NOP;
	assign port_pins = PIN_LEVEL;
endmodule // prog_mem

// ==== logic/axil_regs.sv ====
module axil_regs (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [3:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [31:0] state_word,
	output logic [1:0] ctrl,
	output logic wake
);
	logic [3:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic w_lane0_q;
	logic do_write;
	logic wr_hit;
	logic rd_hit;
	logic [31:0] rd_data;

	// ==========================================
	// Write channel
	assign do_write = !awready && !wready && !bvalid;
	assign wr_hit = (aw_addr_q == core_pkg::REG_CTRL) || (aw_addr_q == core_pkg::REG_WAKE);
	assign rd_hit = (araddr == core_pkg::REG_CTRL) || (araddr == core_pkg::REG_STATE);
	assign rd_data = (araddr == core_pkg::REG_CTRL) ? {30'h00000000, ctrl} :
		(araddr == core_pkg::REG_STATE) ? state_word : 32'h00000000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= core_pkg::RESP_OKAY;
			aw_addr_q <= 4'h0;
			w_data_q <= 32'h00000000;
			w_lane0_q <= 1'b0;
			ctrl <= core_pkg::CTRL_RST;
			wake <= 1'b0;
		end else begin
			wake <= do_write && aw_addr_q == core_pkg::REG_WAKE && w_lane0_q && w_data_q[0];
			if (awvalid && awready) begin
				awready <= 1'b0;
				aw_addr_q <= awaddr;
			end
			if (wvalid && wready) begin
				wready <= 1'b0;
				w_data_q <= wdata;
				w_lane0_q <= wstrb[0];
			end
			if (do_write) begin
				bvalid <= 1'b1;
				bresp <= wr_hit ? core_pkg::RESP_OKAY : core_pkg::RESP_DECERR;
				if (aw_addr_q == core_pkg::REG_CTRL && w_lane0_q) begin
					ctrl <= w_data_q[1:0];
				end
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// ==========================================
	// Read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= core_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_data;
			rresp <= rd_hit ? core_pkg::RESP_OKAY : core_pkg::RESP_DECERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end
endmodule // axil_regs

// ==== logic/core_pkg.sv ====
package core_pkg;
	// ==========================================
	// Core sizes and timing
	localparam int IP_W = 11;
	localparam int SP_W = 3;
	localparam int STACK_DEPTH = 8;
	localparam int FILE_DEPTH = 128;
	localparam int CLOCKS_PER_INSTR = 4;
	// ==========================================
	// Instruction classes and opcodes
	localparam logic [1:0] CLS_BYTE = 2'h0;
	localparam logic [1:0] CLS_BIT = 2'h1;
	localparam logic [1:0] CLS_JUMP = 2'h2;
	localparam logic [1:0] CLS_LIT = 2'h3;
	localparam logic [3:0] OP_MOVWF = 4'h0;
	localparam logic [3:0] OP_CLR = 4'h1;
	localparam logic [3:0] OP_SUB = 4'h2;
	localparam logic [3:0] OP_DEC = 4'h3;
	localparam logic [3:0] OP_IOR = 4'h4;
	localparam logic [3:0] OP_AND = 4'h5;
	localparam logic [3:0] OP_XOR = 4'h6;
	localparam logic [3:0] OP_ADD = 4'h7;
	localparam logic [3:0] OP_MOV = 4'h8;
	localparam logic [3:0] OP_COM = 4'h9;
	localparam logic [3:0] OP_INC = 4'hA;
	localparam logic [3:0] OP_DECSZ = 4'hB;
	localparam logic [3:0] OP_ROR = 4'hC;
	localparam logic [3:0] OP_ROL = 4'hD;
	localparam logic [3:0] OP_SWAP = 4'hE;
	localparam logic [3:0] OP_INCSZ = 4'hF;
	localparam logic [1:0] BOP_CLR = 2'h0;
	localparam logic [1:0] BOP_SET = 2'h1;
	localparam logic [1:0] BOP_TSC = 2'h2;
	localparam logic [1:0] BOP_TSS = 2'h3;
	localparam logic [1:0] LOP_MOVE = 2'h0;
	localparam logic [1:0] LOP_RET = 2'h1;
	localparam logic [1:0] LOP_LOGIC = 2'h2;
	localparam logic [1:0] LOP_ARITH = 2'h3;
	localparam logic [1:0] LOG_IOR = 2'h0;
	localparam logic [1:0] LOG_AND = 2'h1;
	localparam logic [1:0] LOG_XOR = 2'h2;
	localparam logic [13:0] W_KICK = 14'h0064;
	localparam logic [13:0] W_STANDBY = 14'h0063;
	localparam logic [13:0] W_IRET = 14'h0009;
	localparam logic [13:0] W_RET = 14'h0008;
	localparam logic [13:0] W_NOP = 14'h0000;
	// ==========================================
	// File register map and fields
	localparam logic [6:0] F_TIMER = 7'h01;
	localparam logic [6:0] F_PCL = 7'h02;
	localparam logic [6:0] F_STATUS = 7'h03;
	localparam logic [6:0] F_PORT = 7'h05;
	localparam logic [6:0] F_INTCON = 7'h0B;
	localparam int ST_C = 0;
	localparam int ST_NIB = 1;
	localparam int ST_Z = 2;
	localparam int ST_SLP = 3;
	localparam int ST_TMO = 4;
	localparam int IC_PCF = 0;
	localparam int IC_GIE = 7;
	localparam logic [7:0] STATUS_RST = 8'h18;
	localparam logic [7:0] INTCON_RST = 8'h00;
	localparam logic [7:0] PORT_RST = 8'h00;
	// ==========================================
	// Bus register map
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATE = 4'h4;
	localparam logic [3:0] REG_WAKE = 4'h8;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_PSA = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam int STATE_W_LSB = 0;
	localparam int STATE_ST_LSB = 8;
	localparam int STATE_IP_LSB = 16;
	localparam int STATE_SLEEP = 31;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// ==== logic/exec_alu.sv ====
module exec_alu (
	input wire logic [13:0] instr,
	input wire logic [7:0] fval,
	input wire logic [7:0] w,
	input wire logic carry_in,
	output logic [7:0] res,
	output logic wr_w,
	output logic wr_f,
	output logic c_we,
	output logic c_val,
	output logic nib_we,
	output logic nib_val,
	output logic z_we,
	output logic z_val,
	output logic skip
);
	logic [7:0] opa;
	logic [7:0] opb;
	logic cin;
	logic arith;
	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] bmask;

	assign sum = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
	assign nib = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
	assign bmask = 8'h01 << instr[9:7];
	assign z_val = (res == 8'h00);

	always_comb begin
		opa = w;
		opb = fval;
		cin = 1'b0;
		arith = 1'b0;
		res = fval;
		wr_w = 1'b0;
		wr_f = 1'b0;
		c_we = 1'b0;
		c_val = 1'b0;
		nib_we = 1'b0;
		nib_val = 1'b0;
		z_we = 1'b0;
		skip = 1'b0;
		unique case (instr[13:12])
			core_pkg::CLS_BYTE: begin
				wr_f = instr[7];
				wr_w = !instr[7];
				z_we = 1'b1;
				unique case (instr[11:8])
					core_pkg::OP_MOVWF: begin
						res = w;
						wr_w = 1'b0;
						z_we = 1'b0;
					end
					core_pkg::OP_CLR: res = 8'h00;
					core_pkg::OP_SUB: begin
						opa = fval;
						opb = ~w;
						cin = 1'b1;
						arith = 1'b1;
					end
					core_pkg::OP_DEC: res = fval - 8'h01;
					core_pkg::OP_IOR: res = w | fval;
					core_pkg::OP_AND: res = w & fval;
					core_pkg::OP_XOR: res = w ^ fval;
					core_pkg::OP_ADD: arith = 1'b1;
					core_pkg::OP_MOV: res = fval;
					core_pkg::OP_COM: res = ~fval;
					core_pkg::OP_INC: res = fval + 8'h01;
					core_pkg::OP_DECSZ: begin
						res = fval - 8'h01;
						z_we = 1'b0;
						skip = (fval == 8'h01);
					end
					core_pkg::OP_ROR: begin
						res = {carry_in, fval[7:1]};
						z_we = 1'b0;
						c_we = 1'b1;
						c_val = fval[0];
					end
					core_pkg::OP_ROL: begin
						res = {fval[6:0], carry_in};
						z_we = 1'b0;
						c_we = 1'b1;
						c_val = fval[7];
					end
					core_pkg::OP_SWAP: begin
						res = {fval[3:0], fval[7:4]};
						z_we = 1'b0;
					end
					core_pkg::OP_INCSZ: begin
						res = fval + 8'h01;
						z_we = 1'b0;
						skip = (fval == 8'hFF);
					end
				endcase
			end
			core_pkg::CLS_BIT: begin
				unique case (instr[11:10])
					core_pkg::BOP_CLR: begin
						res = fval & ~bmask;
						wr_f = 1'b1;
					end
					core_pkg::BOP_SET: begin
						res = fval | bmask;
						wr_f = 1'b1;
					end
					core_pkg::BOP_TSC: skip = ((fval & bmask) == 8'h00);
					core_pkg::BOP_TSS: skip = ((fval & bmask) != 8'h00);
				endcase
			end
			core_pkg::CLS_JUMP: begin
				res = fval;
			end
			core_pkg::CLS_LIT: begin
				res = instr[7:0];
				wr_w = 1'b1;
				unique case (instr[11:10])
					core_pkg::LOP_MOVE, core_pkg::LOP_RET: res = instr[7:0];
					core_pkg::LOP_LOGIC: begin
						z_we = 1'b1;
						if (instr[9:8] == core_pkg::LOG_IOR) begin
							res = w | instr[7:0];
						end else if (instr[9:8] == core_pkg::LOG_AND) begin
							res = w & instr[7:0];
						end else if (instr[9:8] == core_pkg::LOG_XOR) begin
							res = w ^ instr[7:0];
						end else begin
							wr_w = 1'b0;
							z_we = 1'b0;
						end
					end
					core_pkg::LOP_ARITH: begin
						arith = 1'b1;
						opa = instr[9] ? w : instr[7:0];
						opb = instr[9] ? instr[7:0] : ~w;
						cin = !instr[9];
					end
				endcase
			end
		endcase
		if (arith) begin
			res = sum[7:0];
			c_we = 1'b1;
			c_val = sum[8];
			nib_we = 1'b1;
			nib_val = nib[4];
			z_we = 1'b1;
		end
	end
endmodule // exec_alu

// ==== logic/mcu_instruction_decoder.sv ====
// Function
// - Every file-register instruction reads the register before modifying and storing it.
// - Port register reads return synchronised pin levels, not the output latch.
// - Seven-bit register index reaches file addresses 0x00 through 0x7F.
// - Destination bit zero stores to accumulator, one stores back to file.
// - Bit clear and set pick one of eight bits, flags untouched.
// - Bit tests skip the next instruction on clear or on set.
// - Branches and true tests take two cycles, second one a no-op.
// - Decrement or increment with skip on zero result, flags untouched.
// - Rotates go through carry and change only carry.
// - Accumulator-file OR, XOR, AND update only the zero flag.
// - Clear file reads first, writes zero, sets zero; port read ends mismatch.
// - Literal subtract and add update carry, nibble carry and zero.
// - Literal OR, XOR, AND with accumulator update only the zero flag.
// - Watchdog kick clears the watchdog, sets timeout and sleep bits.
// - Standby enters sleep, sets timeout bit, clears sleep bit.
// - Interrupt return and subroutine return pop the stack in two cycles.
// - Return with literal loads accumulator and returns in two cycles.
// - File write of timer count clears prescaler when assigned to timer.
// - Don't-care opcode bits are ignored, either value accepted.
// - Each instruction cycle spans four clock periods.
module mcu_instruction_decoder (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [10:0] prog_addr,
	input wire logic [13:0] prog_data,
	input wire logic [7:0] port_pins,
	output logic [7:0] port_latch,
	output logic wdt_clear,
	output logic prescaler_clear,
	output logic standby
);
	typedef enum logic [1:0] {ST_FETCH, ST_LATCH, ST_READ, ST_EXEC} phase_e;

	// ==========================================
	// State
	phase_e phase_q;
	logic [10:0] ip_q;
	logic [10:0] ip_d;
	logic [10:0] prog_addr_q;
	logic [13:0] instr_q;
	logic [7:0] fval_q;
	logic [7:0] w_q;
	logic [7:0] status_q;
	logic [7:0] status_d;
	logic [7:0] intcon_q;
	logic [7:0] port_latch_q;
	logic [7:0] port_seen_q;
	logic [7:0] pins_meta_q;
	logic [7:0] pins_sync_q;
	logic nop_cycle_q;
	logic standby_q;
	logic wdt_clear_q;
	logic psc_clear_q;
	logic [10:0] stack_q [core_pkg::STACK_DEPTH];
	logic [2:0] sp_q;
	logic [7:0] mem_q [core_pkg::FILE_DEPTH];

	// ==========================================
	// Bus and execution wires
	logic [1:0] ctrl;
	logic wake;
	logic [31:0] state_word;
	logic [7:0] alu_res;
	logic alu_wr_w;
	logic alu_wr_f;
	logic alu_c_we;
	logic alu_c;
	logic alu_nib_we;
	logic alu_nib;
	logic alu_z_we;
	logic alu_z;
	logic alu_skip;
	logic running;
	logic exec;
	logic [1:0] cls;
	logic [6:0] faddr;
	logic file_ref;
	logic is_call;
	logic is_jump;
	logic is_ret;
	logic is_iret;
	logic is_ret_lit;
	logic is_kick;
	logic is_standby;
	logic is_pop;
	logic wr_f_en;
	logic pcl_write;
	logic two_cycle;
	logic [7:0] rd_val;
	logic [10:0] ip_inc;
	logic [10:0] stack_top;

	assign state_word = {standby_q, 4'h0, ip_q, status_q, w_q};
	assign running = ctrl[core_pkg::CTRL_RUN] && !standby_q;
	assign exec = running && (phase_q == ST_EXEC);
	assign cls = instr_q[13:12];
	assign faddr = instr_q[6:0];
	assign file_ref = (cls == core_pkg::CLS_BIT) || ((cls == core_pkg::CLS_BYTE) &&
		!((instr_q[11:9] == 3'h0) && !instr_q[7]));
	assign is_call = (cls == core_pkg::CLS_JUMP) && !instr_q[11];
	assign is_jump = (cls == core_pkg::CLS_JUMP) && instr_q[11];
	assign is_ret = (instr_q == core_pkg::W_RET);
	assign is_iret = (instr_q == core_pkg::W_IRET);
	assign is_ret_lit = (cls == core_pkg::CLS_LIT) &&
		(instr_q[11:10] == core_pkg::LOP_RET);
	assign is_kick = (instr_q == core_pkg::W_KICK);
	assign is_standby = (instr_q == core_pkg::W_STANDBY);
	assign is_pop = is_ret || is_iret || is_ret_lit;
	assign wr_f_en = exec && file_ref && alu_wr_f;
	assign pcl_write = wr_f_en && (faddr == core_pkg::F_PCL);
	assign two_cycle = !nop_cycle_q &&
		(is_call || is_jump || is_pop || pcl_write || alu_skip);
	assign ip_inc = ip_q + 11'h001;
	assign stack_top = stack_q[sp_q - 3'h1];
	assign prog_addr = prog_addr_q;
	assign port_latch = port_latch_q;
	assign wdt_clear = wdt_clear_q;
	assign prescaler_clear = psc_clear_q;
	assign standby = standby_q;

	// ==========================================
	// File read selection
	assign rd_val = (faddr == core_pkg::F_PORT) ? pins_sync_q :
		(faddr == core_pkg::F_STATUS) ? status_q :
		(faddr == core_pkg::F_PCL) ? ip_q[7:0] :
		(faddr == core_pkg::F_INTCON) ? intcon_q : mem_q[faddr];

	axil_regs u_regs (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(s_axi_awaddr),
		.awvalid(s_axi_awvalid),
		.awready(s_axi_awready),
		.wdata(s_axi_wdata),
		.wstrb(s_axi_wstrb),
		.wvalid(s_axi_wvalid),
		.wready(s_axi_wready),
		.bresp(s_axi_bresp),
		.bvalid(s_axi_bvalid),
		.bready(s_axi_bready),
		.araddr(s_axi_araddr),
		.arvalid(s_axi_arvalid),
		.arready(s_axi_arready),
		.rdata(s_axi_rdata),
		.rresp(s_axi_rresp),
		.rvalid(s_axi_rvalid),
		.rready(s_axi_rready),
		.state_word(state_word),
		.ctrl(ctrl),
		.wake(wake)
	);

	exec_alu u_alu (
		.instr(instr_q),
		.fval(fval_q),
		.w(w_q),
		.carry_in(status_q[core_pkg::ST_C]),
		.res(alu_res),
		.wr_w(alu_wr_w),
		.wr_f(alu_wr_f),
		.c_we(alu_c_we),
		.c_val(alu_c),
		.nib_we(alu_nib_we),
		.nib_val(alu_nib),
		.z_we(alu_z_we),
		.z_val(alu_z),
		.skip(alu_skip)
	);

	// ==========================================
	// Next instruction pointer
	always_comb begin
		ip_d = ip_q;
		if (nop_cycle_q) begin
			ip_d = ip_q;
		end else if (is_call || is_jump) begin
			ip_d = instr_q[10:0];
		end else if (is_pop) begin
			ip_d = stack_top;
		end else if (pcl_write) begin
			ip_d = {ip_q[10:8], alu_res};
		end else if (alu_skip) begin
			ip_d = ip_q + 11'h002;
		end else begin
			ip_d = ip_inc;
		end
	end

	// ==========================================
	// Status flags
	always_comb begin
		status_d = status_q;
		if (wr_f_en && faddr == core_pkg::F_STATUS) begin
			status_d = {alu_res[7:5], status_q[4:3], alu_res[2:0]};
		end
		if (alu_c_we) begin
			status_d[core_pkg::ST_C] = alu_c;
		end
		if (alu_nib_we) begin
			status_d[core_pkg::ST_NIB] = alu_nib;
		end
		if (alu_z_we) begin
			status_d[core_pkg::ST_Z] = alu_z;
		end
		if (is_kick) begin
			status_d[core_pkg::ST_TMO] = 1'b1;
			status_d[core_pkg::ST_SLP] = 1'b1;
		end
		if (is_standby) begin
			status_d[core_pkg::ST_TMO] = 1'b1;
			status_d[core_pkg::ST_SLP] = 1'b0;
		end
	end

	// ==========================================
	// Pin synchroniser
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pins_meta_q <= 8'h00;
			pins_sync_q <= 8'h00;
		end else begin
			pins_meta_q <= port_pins;
			pins_sync_q <= pins_meta_q;
		end
	end

	// ==========================================
	// Instruction cycle sequencing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_q <= ST_FETCH;
			prog_addr_q <= 11'h000;
			instr_q <= core_pkg::W_NOP;
			fval_q <= 8'h00;
			nop_cycle_q <= 1'b0;
		end else if (running) begin
			unique case (phase_q)
				ST_FETCH: begin
					prog_addr_q <= ip_q;
					phase_q <= ST_LATCH;
				end
				ST_LATCH: begin
					instr_q <= nop_cycle_q ? core_pkg::W_NOP : prog_data;
					phase_q <= ST_READ;
				end
				ST_READ: begin
					fval_q <= rd_val;
					phase_q <= ST_EXEC;
				end
				ST_EXEC: begin
					nop_cycle_q <= two_cycle;
					phase_q <= ST_FETCH;
				end
			endcase
		end
	end

	// ==========================================
	// Execution results
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ip_q <= 11'h000;
			w_q <= 8'h00;
			status_q <= core_pkg::STATUS_RST;
			sp_q <= 3'h0;
			standby_q <= 1'b0;
			wdt_clear_q <= 1'b0;
			psc_clear_q <= 1'b0;
			port_latch_q <= core_pkg::PORT_RST;
		end else begin
			wdt_clear_q <= exec && (is_kick || is_standby);
			psc_clear_q <= wr_f_en && faddr == core_pkg::F_TIMER && ctrl[core_pkg::CTRL_PSA];
			if (wake) begin
				standby_q <= 1'b0;
			end else if (exec && is_standby) begin
				standby_q <= 1'b1;
			end
			if (exec) begin
				ip_q <= ip_d;
				status_q <= status_d;
				if (alu_wr_w) begin
					w_q <= alu_res;
				end
				if (wr_f_en && faddr == core_pkg::F_PORT) begin
					port_latch_q <= alu_res;
				end
				if (is_call) begin
					sp_q <= sp_q + 3'h1;
				end else if (is_pop) begin
					sp_q <= sp_q - 3'h1;
				end
			end
		end
	end

	// ==========================================
	// Pin change mismatch and interrupt control
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_seen_q <= 8'h00;
			intcon_q <= core_pkg::INTCON_RST;
		end else begin
			if (phase_q == ST_READ && running && file_ref && faddr == core_pkg::F_PORT) begin
				port_seen_q <= pins_sync_q;
			end
			if (wr_f_en && faddr == core_pkg::F_INTCON) begin
				intcon_q <= alu_res;
			end else if (exec && is_iret) begin
				intcon_q[core_pkg::IC_GIE] <= 1'b1;
			end
			if (pins_sync_q != port_seen_q) begin
				intcon_q[core_pkg::IC_PCF] <= 1'b1;
			end
		end
	end

	// ==========================================
	// Storage arrays
	always_ff @(posedge aclk) begin
		if (exec && is_call) begin
			stack_q[sp_q] <= ip_inc;
		end
		if (wr_f_en) begin
			mem_q[faddr] <= alu_res;
		end
	end
endmodule // mcu_instruction_decoder
